// File: logic/ifd_defines.svh
/*
 * Constants for the instruction format and timing front end: category
 * codes of the word layout, sub-codes and cycle counts.
 * Assumes inclusion by bare name from every file that needs it.
 */
`ifndef IFD_DEFINES_SVH
`define IFD_DEFINES_SVH

// ****************************************************************
// timing
// ****************************************************************
`define IFD_OSC_PER_CYC  3'h4      // oscillator periods per instruction cycle
`define IFD_PHASE_LAST   2'h3      // last phase of a cycle
`define IFD_CYC_SINGLE   2'h1
`define IFD_CYC_DOUBLE   2'h2

// ****************************************************************
// word layout: top nibble selects the group
// ****************************************************************
`define IFD_NIB_LIT      4'hC      // literal group
`define IFD_NIB_MOVFF    4'hD      // file-to-file move, first of two words
`define IFD_NIB_CTRL     4'hE      // control group
`define IFD_NIB_CONT     4'hF      // second word of a double-word instruction

// literal sub-codes
`define IFD_LIT_PTRLD    4'h7      // load indirect pointer, first of two words
`define IFD_LIT_EXT_MIN  4'h8      // sub-codes 8..F are the extended set

// control sub-codes
`define IFD_CTL_NOP      4'h0
`define IFD_CTL_RETURN   4'h1
`define IFD_CTL_TABLE    4'h2
`define IFD_CTL_BRA      4'h3
`define IFD_CTL_BCOND    4'h4
`define IFD_CTL_CALL     4'h5
`define IFD_CTL_CALLF    4'h6
`define IFD_CTL_GOTO     4'h7
`define IFD_CTL_SKIP     4'h9

// reset values
`define IFD_WORD_RST     16'h0000
`define IFD_ADDR_RST     20'h00000

`endif

// File: logic/ifd_pkg.sv
/*
 * Types shared by the instruction format and timing front end.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ifd_pkg;

  // instruction category
  typedef enum logic [1:0] {
    IFD_CAT_BYTE = 2'h0,
    IFD_CAT_BIT  = 2'h1,
    IFD_CAT_LIT  = 2'h2,
    IFD_CAT_CTRL = 2'h3
  } ifd_cat_e;

  // table pointer mode
  typedef enum logic [1:0] {
    IFD_TBL_KEEP     = 2'h0,
    IFD_TBL_POST_INC = 2'h1,
    IFD_TBL_POST_DEC = 2'h2,
    IFD_TBL_PRE_INC  = 2'h3
  } ifd_tbl_e;

  // which double-word instruction is half done
  typedef enum logic [1:0] {
    IFD_DW_PTRLD = 2'h0,
    IFD_DW_MOVFF = 2'h1,
    IFD_DW_CALL  = 2'h2,
    IFD_DW_GOTO  = 2'h3
  } ifd_dw_e;

  // sequencer state
  typedef enum logic [1:0] {
    IFD_ST_EXEC   = 2'h0,
    IFD_ST_SECOND = 2'h1,
    IFD_ST_FLUSH  = 2'h2
  } ifd_state_e;

endpackage : ifd_pkg

// File: logic/ifd_dec_if.sv
/*
 * Decoded fields of one program word, passed from the field decoder to
 * the sequencer. Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/100ps
interface ifd_dec_if;
  import ifd_pkg::*;
  ifd_cat_e    cat;
  logic [5:0]  opcode;
  logic [7:0]  f_addr;
  logic        dest_file;
  logic        use_bank;
  logic [2:0]  bit_idx;
  logic [7:0]  lit;
  logic [1:0]  ptr_sel;
  logic        fast;
  ifd_tbl_e    tbl_mode;
  logic        tbl_write;
  logic        is_double;
  ifd_dw_e     dw_kind;
  logic        is_cont;
  logic        is_ext;
  logic        pc_change;
  logic        is_cond;
  logic        is_return;
  logic        is_nop;

  modport producer (output cat, opcode, f_addr, dest_file, use_bank, bit_idx, lit, ptr_sel,
                    fast, tbl_mode, tbl_write, is_double, dw_kind, is_cont, is_ext,
                    pc_change, is_cond, is_return, is_nop);
  modport consumer (input cat, opcode, f_addr, dest_file, use_bank, bit_idx, lit, ptr_sel,
                    fast, tbl_mode, tbl_write, is_double, dw_kind, is_cont, is_ext,
                    pc_change, is_cond, is_return, is_nop);
endinterface : ifd_dec_if

// File: logic/ifd_field_decode.sv
/*
 * Combinational split of one 16-bit program word into category and fields.
 * Assumes the word is stable while it is decoded; no state is held here.
 */
`timescale 1ns/100ps
`include "ifd_defines.svh"
module ifd_field_decode
  import ifd_pkg::*;
(
  // word in
  input  wire logic [15:0] word,
  input  wire logic        ext_en,
  // fields out
  ifd_dec_if.producer      dec
);

  // ****************************************************************
  // field split
  // ****************************************************************
  // opcode first, operands after; every field has a default
  always_comb begin
    dec.cat       = IFD_CAT_CTRL;
    dec.opcode    = word[15:10];
    dec.f_addr    = word[7:0];
    dec.dest_file = 1'b0;
    dec.use_bank  = 1'b0;
    dec.bit_idx   = 3'h0;
    dec.lit       = word[7:0];
    dec.ptr_sel   = word[5:4];
    dec.fast      = 1'b0;
    dec.tbl_mode  = ifd_tbl_e'(word[1:0]);
    dec.tbl_write = 1'b0;
    dec.is_double = 1'b0;
    dec.dw_kind   = IFD_DW_GOTO;
    dec.is_cont   = 1'b0;
    dec.is_ext    = 1'b0;
    dec.pc_change = 1'b0;
    dec.is_cond   = 1'b0;
    dec.is_return = 1'b0;
    dec.is_nop    = 1'b0;
    if (word[15] == 1'b0) begin
      dec.cat       = IFD_CAT_BYTE;
      dec.dest_file = word[9];
      dec.use_bank  = word[8];
    end else if (word[15:14] == 2'h2) begin
      dec.cat      = IFD_CAT_BIT;
      dec.opcode   = {4'h0, word[13:12]};
      dec.bit_idx  = word[11:9];
      dec.use_bank = word[8];
    end else if (word[15:12] == `IFD_NIB_LIT) begin
      dec.cat    = IFD_CAT_LIT;
      dec.opcode = {2'h0, word[11:8]};
      if (word[11:8] == `IFD_LIT_PTRLD) begin
        dec.is_double = 1'b1;
        dec.dw_kind   = IFD_DW_PTRLD;
      end else if (word[11:8] >= `IFD_LIT_EXT_MIN) begin
        // extended set is only recognised when enabled, else a no-op
        dec.is_ext = ext_en;
        dec.is_nop = !ext_en;
      end
    end else if (word[15:12] == `IFD_NIB_MOVFF) begin
      dec.cat       = IFD_CAT_BYTE;
      dec.is_double = 1'b1;
      dec.dw_kind   = IFD_DW_MOVFF;
    end else if (word[15:12] == `IFD_NIB_CTRL) begin
      dec.cat    = IFD_CAT_CTRL;
      dec.opcode = {2'h0, word[11:8]};
      if (word[11:8] == `IFD_CTL_NOP) begin
        dec.is_nop = 1'b1;
      end else if (word[11:8] == `IFD_CTL_RETURN) begin
        dec.is_return = 1'b1;
        dec.pc_change = 1'b1;
        dec.fast      = word[0];
      end else if (word[11:8] == `IFD_CTL_TABLE) begin
        dec.tbl_write = word[2];
      end else if (word[11:8] == `IFD_CTL_BRA) begin
        dec.pc_change = 1'b1;
      end else if (word[11:8] == `IFD_CTL_BCOND || word[11:8] == `IFD_CTL_SKIP) begin
        dec.is_cond = 1'b1;
      end else if (word[11:8] == `IFD_CTL_CALL || word[11:8] == `IFD_CTL_CALLF) begin
        dec.is_double = 1'b1;
        dec.dw_kind   = IFD_DW_CALL;
        dec.fast      = word[9];
      end else if (word[11:8] == `IFD_CTL_GOTO) begin
        dec.is_double = 1'b1;
        dec.dw_kind   = IFD_DW_GOTO;
      end else begin
        dec.is_nop = 1'b1;
      end
    end else begin
      // a lone second word runs as a no-op
      dec.is_cont = 1'b1;
      dec.is_nop  = 1'b1;
    end
  end

endmodule : ifd_field_decode

// File: logic/ifd_core_front.sv
/*
 * Instruction format and timing front end: divides the core clock into
 * instruction cycles, decodes each fetched word, completes double-word
 * instructions and inserts discarded no-op cycles after pc changes.
 * Assumes program memory presents the word for the current instruction
 * cycle on fetch_word, stable at the last phase of that cycle.
 */
`timescale 1ns/100ps
`include "ifd_defines.svh"
module ifd_core_front
  import ifd_pkg::*;
(
  // clock and reset
  input  wire  logic        sys_clk,
  input  wire  logic        sys_rst,
  // program word and status in
  input  wire  logic [15:0] fetch_word,
  input  wire  logic        ext_en,
  input  wire  logic        cond_true,
  // timing out
  output logic              cyc_strobe,
  output logic              issue,
  output logic              nop_cycle,
  output logic [1:0]        cycles,
  // decoded instruction out
  output ifd_cat_e          cat,
  output logic [5:0]        opcode,
  output logic              is_ext,
  output logic [11:0]       f_addr,
  output logic [11:0]       f_dst,
  output logic              wr_accumulator,
  output logic              wr_file,
  output logic              use_bank,
  output logic [2:0]        bit_idx,
  output logic [11:0]       lit,
  output logic [1:0]        ptr_sel,
  output logic [19:0]       target,
  output logic              shadow_save,
  output logic              shadow_restore,
  output ifd_tbl_e          tbl_mode,
  output logic              tbl_write
);

  // ****************************************************************
  // instruction cycle divider
  // ****************************************************************
  logic [1:0]  phase_reg;
  logic        cyc_en;
  ifd_state_e  state_reg;
  ifd_dw_e     dw_kind_reg;

  // free-running phase count; one cycle enable per four clocks
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign cyc_en = (phase_reg == `IFD_PHASE_LAST);

  // strobe is registered so it lines up with the decoded outputs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cyc_strobe <= 1'b0;
    end else begin
      cyc_strobe <= cyc_en;
    end
  end

  // ****************************************************************
  // field decode
  // ****************************************************************
  ifd_dec_if dec ();

  ifd_field_decode u_field_decode (
    .word   (fetch_word),
    .ext_en (ext_en),
    .dec    (dec)
  );

  // joins the first-word bits with the low twelve of the second word
  function automatic logic [19:0] ifd_join(input logic [7:0] hi, input logic [15:0] w2);
    ifd_join = {hi, w2[11:0]};
  endfunction : ifd_join

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // a taken change goes through a flush cycle so the prefetched word
  // never reaches the outputs as a real instruction
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg   <= IFD_ST_EXEC;
      dw_kind_reg <= IFD_DW_GOTO;
    end else if (cyc_en) begin
      case (state_reg)
        IFD_ST_EXEC: begin
          if (dec.is_double) begin
            state_reg   <= IFD_ST_SECOND;
            dw_kind_reg <= dec.dw_kind;
          end else if (dec.pc_change || (dec.is_cond && cond_true)) begin
            state_reg <= IFD_ST_FLUSH;
          end else begin
            state_reg <= IFD_ST_EXEC;
          end
        end
        IFD_ST_SECOND: begin
          state_reg <= IFD_ST_EXEC;
        end
        IFD_ST_FLUSH: begin
          state_reg <= IFD_ST_EXEC;
        end
        default: begin
          state_reg <= IFD_ST_EXEC;
        end
      endcase
    end
  end

  // ****************************************************************
  // issue and cycle accounting
  // ****************************************************************
  // issue pulses once per instruction except no-ops, at the cycle that completes it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      issue     <= 1'b0;
      nop_cycle <= 1'b0;
      cycles    <= `IFD_CYC_SINGLE;
    end else if (cyc_en) begin
      issue     <= 1'b0;
      nop_cycle <= 1'b0;
      case (state_reg)
        IFD_ST_EXEC: begin
          issue     <= !dec.is_double && !dec.is_nop;
          nop_cycle <= dec.is_nop;
          if (dec.is_double) begin
            cycles <= `IFD_CYC_DOUBLE;
          end else if (dec.pc_change || (dec.is_cond && cond_true)) begin
            cycles <= `IFD_CYC_DOUBLE;
          end else begin
            cycles <= `IFD_CYC_SINGLE;
          end
        end
        IFD_ST_SECOND: begin
          issue <= 1'b1;
        end
        default: begin
          nop_cycle <= 1'b1;
        end
      endcase
    end else begin
      issue     <= 1'b0;
      nop_cycle <= 1'b0;
    end
  end

  // ****************************************************************
  // operand fields
  // ****************************************************************
  // operands load in the execute state and are completed by the second
  // word; flush cycles leave them alone so nothing new is acted on
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cat            <= IFD_CAT_CTRL;
      opcode         <= 6'h00;
      is_ext         <= 1'b0;
      f_addr         <= 12'h000;
      f_dst          <= 12'h000;
      use_bank       <= 1'b0;
      bit_idx        <= 3'h0;
      lit            <= 12'h000;
      ptr_sel        <= 2'h0;
      target         <= `IFD_ADDR_RST;
      tbl_mode       <= IFD_TBL_KEEP;
      tbl_write      <= 1'b0;
    end else if (cyc_en && state_reg == IFD_ST_EXEC) begin
      cat       <= dec.cat;
      opcode    <= dec.opcode;
      is_ext    <= dec.is_ext;
      f_addr    <= (dec.dw_kind == IFD_DW_MOVFF && dec.is_double) ?
                   fetch_word[11:0] : {4'h0, dec.f_addr};
      use_bank  <= dec.use_bank;
      bit_idx   <= dec.bit_idx;
      lit       <= {4'h0, dec.lit};
      ptr_sel   <= dec.ptr_sel;
      target    <= {12'h000, dec.lit};
      tbl_mode  <= dec.tbl_mode;
      tbl_write <= dec.tbl_write;
    end else if (cyc_en && state_reg == IFD_ST_SECOND) begin
      case (dw_kind_reg)
        IFD_DW_PTRLD: begin
          lit <= {lit[3:0], fetch_word[7:0]};
        end
        IFD_DW_MOVFF: begin
          f_dst <= fetch_word[11:0];
        end
        default: begin
          target <= ifd_join(target[7:0], fetch_word);
        end
      endcase
    end
  end

  // ****************************************************************
  // result destination and shadow control
  // ****************************************************************
  // destination bit steers only byte-oriented results
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_accumulator <= 1'b0;
      wr_file        <= 1'b0;
    end else if (cyc_en && state_reg == IFD_ST_EXEC) begin
      wr_accumulator <= dec.cat == IFD_CAT_BYTE && !dec.is_double && !dec.dest_file;
      wr_file        <= dec.cat == IFD_CAT_BYTE && !dec.is_double && dec.dest_file;
    end else if (cyc_en) begin
      wr_accumulator <= 1'b0;
      wr_file        <= 1'b0;
    end
  end

  // shadow save holds from the call's first word through its completing cycle, restore rides the return
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shadow_save    <= 1'b0;
      shadow_restore <= 1'b0;
    end else if (cyc_en && state_reg == IFD_ST_EXEC) begin
      shadow_save    <= dec.is_double && dec.dw_kind == IFD_DW_CALL && dec.fast;
      shadow_restore <= dec.is_return && dec.fast;
    end else if (cyc_en) begin
      shadow_restore <= 1'b0;
      if (state_reg != IFD_ST_SECOND) begin
        shadow_save <= 1'b0;
      end
    end
  end

endmodule : ifd_core_front

// File: dv/ifd_core_front_properties.sv
/*
 * Concurrent checks on the ports of the instruction front end.
 * Assumes one clock domain and a bind from the bench top file.
 */
`timescale 1ns/100ps
`include "ifd_defines.svh"
module ifd_core_front_properties
  import ifd_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // program word
  input wire logic [15:0] fetch_word,
  // timing
  input wire logic        cyc_strobe,
  input wire logic        issue,
  input wire logic        nop_cycle,
  input wire logic [1:0]  cycles,
  // decoded fields
  input wire ifd_cat_e    cat,
  input wire logic        wr_accumulator,
  input wire logic        wr_file,
  input wire logic        use_bank,
  input wire logic [2:0]  bit_idx,
  input wire logic [11:0] f_addr,
  input wire logic        shadow_restore,
  input wire ifd_tbl_e    tbl_mode,
  input wire logic        tbl_write
);
  // ****************************************************************
  // checks
  // ****************************************************************
  // reset aborts every attempt, so a half-done pair is not flagged
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  strobe_period_a: assert property (cyc_strobe |=> !cyc_strobe [*3] ##1 cyc_strobe)
    else $error("instruction cycle strobe spacing wrong");
  pulse_on_strobe_a: assert property ((issue || nop_cycle) |-> cyc_strobe)
    else $error("issue or nop pulse off the cycle strobe");
  dest_select_a: assert property (issue && cat == IFD_CAT_BYTE && cycles == 2'h1
    |-> wr_file == $past(fetch_word[9]) && wr_accumulator != wr_file)
    else $error("destination select wrong");
  bank_select_a: assert property (issue && cat inside {IFD_CAT_BYTE, IFD_CAT_BIT}
    && cycles == 2'h1 |-> use_bank == $past(fetch_word[8])
    && f_addr == {4'h0, $past(fetch_word[7:0])})
    else $error("access select or file address wrong");
  bit_index_a: assert property (issue && cat == IFD_CAT_BIT
    |-> bit_idx == $past(fetch_word[11:9]))
    else $error("bit index wrong");
  double_word_a: assert property (cyc_strobe && !issue && !nop_cycle && cycles == 2'h2
    |-> ##4 (cyc_strobe && issue && cycles == 2'h2))
    else $error("double-word instruction not completed in next cycle");
  // a second word always follows a slot with neither pulse, so a two-cycle
  // issue after an issued or discarded slot is a taken single-word one
  flush_slot_a: assert property (issue && cycles == 2'h2
    && ($past(issue, 4) || $past(nop_cycle, 4)) |-> ##4 (nop_cycle && !issue))
    else $error("cycle after pc change not discarded");
  fast_return_a: assert property (issue && $past(fetch_word[15:8]) == 8'hE1
    |-> shadow_restore == $past(fetch_word[0]))
    else $error("fast return select wrong");
  table_mode_a: assert property (issue && $past(fetch_word[15:8]) == 8'hE2
    |-> tbl_mode == $past(fetch_word[1:0]) && tbl_write == $past(fetch_word[2]))
    else $error("table pointer mode wrong");

  // main scenarios reached
  dw_seen_c: cover property (cyc_strobe && !issue ##4 issue && cycles == 2'h2);
  flush_seen_c: cover property (nop_cycle && !issue);
  bit_seen_c: cover property (issue && cat == IFD_CAT_BIT);
endmodule : ifd_core_front_properties

// File: dv/tb_top.sv
/*
 * Self-checking bench for the instruction front end: directed words,
 * a mid-run reset and a seeded random stream, checked against a model.
 * Assumes the front end samples a word every fourth clock after reset.
 */
`timescale 1ns/100ps
`include "ifd_defines.svh"
module tb_top
  import ifd_pkg::*;
;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        sys_clk, sys_rst, ext_en, cond_true;
  logic [15:0] fetch_word;
  logic        cyc_strobe, issue, nop_cycle, is_ext, wr_accumulator, wr_file;
  logic        use_bank, shadow_save, shadow_restore, tbl_write;
  logic [1:0]  cycles, ptr_sel;
  logic [5:0]  opcode;
  logic [2:0]  bit_idx;
  logic [11:0] f_addr, f_dst, lit;
  logic [19:0] target;
  ifd_cat_e    cat;
  ifd_tbl_e    tbl_mode;
  int          err_count, checked, seed, flush, e_iss, e_nop, e_cyc, e_cat;
  logic [31:0] r;
  logic [15:0] pend_q[$];
  // {ext_en, cond_true, word}; fillers sit in discarded slots
  logic [17:0] dir[$] = '{18'h00312, 18'h00145, 18'h0AB34, 18'h094FF, 18'h0C0A5,
    18'h2C9FF, 18'h0C9FF, 18'h0C712, 18'h0F345, 18'h0D123, 18'h0F456, 18'h0E7AB,
    18'h0FCDE, 18'h0F000, 18'h0E000, 18'h0E305, 18'h000FF, 18'h0E101, 18'h00000,
    18'h0E100, 18'h00000, 18'h1E4F0, 18'h00000, 18'h0E4F0, 18'h1E922, 18'h00000,
    18'h0E612, 18'h0F001, 18'h0E512, 18'h0F777, 18'h0E7AB};

  ifd_core_front u_ifd_core_front (
    .sys_clk        (sys_clk),
    .sys_rst        (sys_rst),
    .fetch_word     (fetch_word),
    .ext_en         (ext_en),
    .cond_true      (cond_true),
    .cyc_strobe     (cyc_strobe),
    .issue          (issue),
    .nop_cycle      (nop_cycle),
    .cycles         (cycles),
    .cat            (cat),
    .opcode         (opcode),
    .is_ext         (is_ext),
    .f_addr         (f_addr),
    .f_dst          (f_dst),
    .wr_accumulator (wr_accumulator),
    .wr_file        (wr_file),
    .use_bank       (use_bank),
    .bit_idx        (bit_idx),
    .lit            (lit),
    .ptr_sel        (ptr_sel),
    .target         (target),
    .shadow_save    (shadow_save),
    .shadow_restore (shadow_restore),
    .tbl_mode       (tbl_mode),
    .tbl_write      (tbl_write)
  );

  // free-running 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // checking
  // ****************************************************************
  task automatic cmp_time(input string name, input int exp, input logic [1:0] got);
    checked++;
    if (got !== exp[1:0]) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp[1:0], got);
    end
  endtask : cmp_time

  task automatic cmp_field(input string name, input int exp, input logic [19:0] got);
    checked++;
    if (got !== exp[19:0]) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp[19:0], got);
    end
  endtask : cmp_field

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task automatic set_exp(input int i, input int n, input int c);
    e_iss = i;
    e_nop = n;
    e_cyc = c;
  endtask : set_exp

  // two-clock reset; the model forgets any half-done pair
  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    pend_q.delete();
    flush = 0;
    @(negedge sys_clk);
    cmp_time("issue", 0, issue);
    cmp_time("cycles", 1, cycles);
    cmp_field("cat", 3, cat);
    @(posedge sys_clk);
  endtask : do_reset

  // one instruction cycle: word held over the four clocks, checked after
  task automatic step(input logic [15:0] w, input logic c, input logic e);
    logic [15:0] f;
    logic [3:0]  hi, sub;
    hi = w[15:12];
    sub = w[11:8];
    set_exp(1, 0, 1);
    e_cat = -1;
    fetch_word <= w;
    cond_true <= c;
    ext_en <= e;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    if (flush != 0) begin
      set_exp(0, 1, 2);
      flush = 0;
    end else if (pend_q.size() > 0) begin
      f = pend_q.pop_front();
      set_exp(1, 0, 2);
      if (f[15:12] == `IFD_NIB_MOVFF) begin
        cmp_field("f_addr", f[11:0], f_addr);
        cmp_field("f_dst", w[11:0], f_dst);
      end else if (f[15:12] == `IFD_NIB_LIT) begin
        cmp_field("lit", {f[3:0], w[7:0]}, lit);
        cmp_field("ptr_sel", f[5:4], ptr_sel);
      end else begin
        cmp_field("target", {f[7:0], w[11:0]}, target);
      end
    end else if (hi == `IFD_NIB_CONT || (hi == `IFD_NIB_CTRL && !(sub inside {[1:7], 9}))
                 || (hi == `IFD_NIB_LIT && sub[3] && !e)) begin
      set_exp(0, 1, 1);
    end else if ({hi, sub} == 8'hC7 || hi == `IFD_NIB_MOVFF || (hi == `IFD_NIB_CTRL)
                 && sub inside {[5:7]}) begin
      set_exp(0, 0, 2);
      pend_q.push_back(w);
      // both call forms are checked so a plain call must leave the shadows alone
      if (hi == `IFD_NIB_CTRL && sub inside {`IFD_CTL_CALL, `IFD_CTL_CALLF}) begin
        cmp_field("shadow_save", w[9], shadow_save);
      end
    end else if (!w[15]) begin
      e_cat = 0;
      cmp_field("opcode", w[15:10], opcode);
      cmp_field("wr_file", w[9], wr_file);
      cmp_field("wr_accumulator", !w[9], wr_accumulator);
      cmp_field("use_bank", w[8], use_bank);
      cmp_field("f_addr", w[7:0], f_addr);
    end else if (!w[14]) begin
      e_cat = 1;
      cmp_field("opcode", w[13:12], opcode);
      cmp_field("bit_idx", w[11:9], bit_idx);
      cmp_field("use_bank", w[8], use_bank);
      cmp_field("f_addr", w[7:0], f_addr);
    end else if (hi == `IFD_NIB_LIT) begin
      e_cat = 2;
      cmp_field("lit", w[7:0], lit);
      cmp_field("ptr_sel", w[5:4], ptr_sel);
      cmp_field("is_ext", sub[3], is_ext);
    end else begin
      e_cat = 3;
      cmp_field("opcode", sub, opcode);
      if (sub == `IFD_CTL_RETURN) begin
        set_exp(1, 0, 2);
        flush = 1;
        cmp_field("shadow_restore", w[0], shadow_restore);
      end else if (sub == `IFD_CTL_TABLE) begin
        cmp_field("tbl_mode", w[1:0], tbl_mode);
        cmp_field("tbl_write", w[2], tbl_write);
      end else if (sub == `IFD_CTL_BRA) begin
        set_exp(1, 0, 2);
        flush = 1;
        cmp_field("target", w[7:0], target);
      end else begin
        set_exp(1, 0, c ? 2 : 1);
        flush = c;
      end
    end
    cmp_time("cyc_strobe", 1, cyc_strobe);
    if (e_iss >= 0) cmp_time("issue", e_iss, issue);
    cmp_time("nop_cycle", e_nop, nop_cycle);
    if (e_cyc >= 0) cmp_time("cycles", e_cyc, cycles);
    if (e_cat >= 0) cmp_field("cat", e_cat, cat);
    @(posedge sys_clk);
  endtask : step

  // ****************************************************************
  // sequence
  // ****************************************************************
  // watchdog: a run that never ends counts as a failure
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    close_out();
  end

  // table modes, directed words, reset over a half pair, then random
  initial begin
    seed = 32'h4b636fa3;
    {sys_rst, ext_en, cond_true, fetch_word} = {3'h4, 16'h0000};
    {err_count, checked, flush} = '0;
    do_reset();
    for (int k = 0; k < 8; k++) step(16'hE200 | 16'(k), 1'b0, 1'b0);
    // the last directed word is a first half, so the reset lands mid-pair
    foreach (dir[i]) step(dir[i][15:0], dir[i][16], dir[i][17]);
    do_reset();
    for (int k = 0; k < 300; k++) begin
      r = $random(seed);
      // the word after a first half is always a continuation word
      step(pend_q.size() > 0 ? {4'hF, r[11:0]} : r[15:0], r[16], r[17]);
    end
    close_out();
  end
endmodule : tb_top

bind ifd_core_front ifd_core_front_properties u_ifd_core_front_properties (
  .sys_clk        (sys_clk),
  .sys_rst        (sys_rst),
  .fetch_word     (fetch_word),
  .cyc_strobe     (cyc_strobe),
  .issue          (issue),
  .nop_cycle      (nop_cycle),
  .cycles         (cycles),
  .cat            (cat),
  .wr_accumulator (wr_accumulator),
  .wr_file        (wr_file),
  .use_bank       (use_bank),
  .bit_idx        (bit_idx),
  .f_addr         (f_addr),
  .shadow_restore (shadow_restore),
  .tbl_mode       (tbl_mode),
  .tbl_write      (tbl_write)
);
